// [hw/aip_consts.vh]
// constants for the accumulator / error flag / interrupt command block
`ifndef AIP_CONSTS_VH
`define AIP_CONSTS_VH
// instruction numbers
`define AIP_OP_ACCU_AXIS     8'h22
`define AIP_OP_ACCU_GLOBAL   8'h23
`define AIP_OP_CLEAR_ERR     8'h24
`define AIP_OP_IRQ_ENABLE    8'h19
`define AIP_OP_IRQ_DISABLE   8'h1a
`define AIP_OP_IRQ_RETURN    8'h26
// clear_error_flags type codes
`define AIP_CLE_ALL          8'h00
`define AIP_CLE_TIMEOUT      8'h01
`define AIP_CLE_ALARM        8'h02
`define AIP_CLE_DEVIATION    8'h03
`define AIP_CLE_POSITION     8'h04
`define AIP_CLE_SHUTDOWN     8'h05
// error flag bit positions
`define AIP_EF_TIMEOUT       0
`define AIP_EF_ALARM         1
`define AIP_EF_DEVIATION     2
`define AIP_EF_POSITION      3
`define AIP_EF_SHUTDOWN      4
`define AIP_EF_W             5
// interrupt number meaning all processing
`define AIP_IRQ_GLOBAL       8'hff
`define AIP_IRQ_N            32
// reply status codes
`define AIP_ST_OK            8'h64
`define AIP_ST_BAD_CSUM      8'h01
`define AIP_ST_BAD_CMD       8'h02
// register offsets
`define AIP_REG_STATUS       4'h0
`define AIP_REG_MASK         4'h1
`define AIP_REG_ERRFLAGS     4'h2
`define AIP_REG_IRQEN        4'h3
`define AIP_REG_GLOBAL_EN    4'h4
`define AIP_REG_ADDR         4'h5
`define AIP_REG_ACCU         4'h6
// status bit positions
`define AIP_IS_CMD_DONE      0
`define AIP_IS_CMD_ERR       1
`define AIP_IS_W             2
// reset value of the module address, fixed host address for replies
`define AIP_RST_ADDR         8'h01
`define AIP_RST_HOST         8'h02
`endif

// [hw/aip_frame_rx.v]
// nine-byte command frame assembler with checksum check
`timescale 1ns/100ps
`include "aip_consts.vh"
module aip_frame_rx (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  output reg         frame_valid,
  output reg         frame_csum_ok,
  output reg  [7:0]  frame_addr,
  output reg  [7:0]  frame_op,
  output reg  [7:0]  frame_type,
  output reg  [7:0]  frame_bank,
  output reg  [31:0] frame_value
);
  reg [3:0]  idx_reg;
  reg [7:0]  sum_reg;
  reg [63:0] sh_reg;
  // =====================================================
  // byte collection
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg       <= 4'h0;
      sum_reg       <= 8'h00;
      sh_reg        <= 64'h0;
      frame_valid   <= 1'b0;
      frame_csum_ok <= 1'b0;
      frame_addr    <= 8'h00;
      frame_op      <= 8'h00;
      frame_type    <= 8'h00;
      frame_bank    <= 8'h00;
      frame_value   <= 32'h0;
    end else begin
      frame_valid <= 1'b0;
      if (byte_valid) begin
        if (idx_reg == 4'h8) begin
          // value bytes arrive msb first, checksum is low byte of sum
          idx_reg       <= 4'h0;
          sum_reg       <= 8'h00;
          frame_valid   <= 1'b1;
          frame_csum_ok <= (sum_reg == byte_data);
          frame_addr    <= sh_reg[63:56];
          frame_op      <= sh_reg[55:48];
          frame_type    <= sh_reg[47:40];
          frame_bank    <= sh_reg[39:32];
          frame_value   <= sh_reg[31:0];
        end else begin
          idx_reg <= idx_reg + 4'h1;
          sum_reg <= sum_reg + byte_data;
          sh_reg  <= {sh_reg[55:0], byte_data};
        end
      end
    end
  end
endmodule // aip_frame_rx

// [hw/aip_cmd_exec.v]
// command executor: accumulator copies, error flag clearing, interrupt enables
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "aip_consts.vh"
module aip_cmd_exec (
  CLK_SYS,
  RST_N,
  RX_VALID,
  RX_DATA,
  PROG_VALID,
  PROG_OP,
  PROG_TYPE,
  PROG_BANK,
  PROG_VALUE,
  ACCU_IN,
  ERR_SET,
  CTX_ACCU,
  CTX_X,
  CTX_FLAGS,
  CTX_PC,
  PAR_WE,
  PAR_GLOBAL,
  PAR_INDEX,
  PAR_BANK,
  PAR_DATA,
  ERR_FLAGS,
  IRQ_EN,
  IRQ_GLOBAL_EN,
  RESTORE_STB,
  RESTORE_ACCU,
  RESTORE_X,
  RESTORE_FLAGS,
  RESTORE_PC,
  REPLY_VALID,
  REPLY_HOST,
  REPLY_ADDR,
  REPLY_STATUS,
  REPLY_CMD,
  REPLY_VALUE,
  REPLY_CSUM,
  REG_ADDR,
  REG_WDATA,
  REG_WR,
  REG_RD,
  REG_RDATA,
  IRQ
);
  input  wire                   CLK_SYS;
  input  wire                   RST_N;
  input  wire                   RX_VALID;
  input  wire [7:0]             RX_DATA;
  input  wire                   PROG_VALID;
  input  wire [7:0]             PROG_OP;
  input  wire [7:0]             PROG_TYPE;
  input  wire [7:0]             PROG_BANK;
  input  wire [31:0]            PROG_VALUE;
  input  wire [31:0]            ACCU_IN;
  input  wire [`AIP_EF_W-1:0]   ERR_SET;
  input  wire [31:0]            CTX_ACCU;
  input  wire [31:0]            CTX_X;
  input  wire [7:0]             CTX_FLAGS;
  input  wire [15:0]            CTX_PC;
  output reg                    PAR_WE;
  output reg                    PAR_GLOBAL;
  output reg  [7:0]             PAR_INDEX;
  output reg  [7:0]             PAR_BANK;
  output reg  [31:0]            PAR_DATA;
  output wire [`AIP_EF_W-1:0]   ERR_FLAGS;
  output wire [`AIP_IRQ_N-1:0]  IRQ_EN;
  output wire                   IRQ_GLOBAL_EN;
  output reg                    RESTORE_STB;
  output reg  [31:0]            RESTORE_ACCU;
  output reg  [31:0]            RESTORE_X;
  output reg  [7:0]             RESTORE_FLAGS;
  output reg  [15:0]            RESTORE_PC;
  output reg                    REPLY_VALID;
  output reg  [7:0]             REPLY_HOST;
  output reg  [7:0]             REPLY_ADDR;
  output reg  [7:0]             REPLY_STATUS;
  output reg  [7:0]             REPLY_CMD;
  output reg  [31:0]            REPLY_VALUE;
  output reg  [7:0]             REPLY_CSUM;
  input  wire [3:0]             REG_ADDR;
  input  wire [31:0]            REG_WDATA;
  input  wire                   REG_WR;
  input  wire                   REG_RD;
  output reg  [31:0]            REG_RDATA;
  output wire                   IRQ;

  wire        fr_valid;
  wire        fr_ok;
  wire [7:0]  fr_addr;
  wire [7:0]  fr_op;
  wire [7:0]  fr_type;
  wire [7:0]  fr_bank;
  wire [31:0] fr_value;

  reg  [`AIP_EF_W-1:0]  err_reg;
  reg  [`AIP_EF_W-1:0]  err_clr;
  reg  [`AIP_IRQ_N-1:0] irq_en_reg;
  reg                   gie_reg;
  reg  [7:0]            addr_reg;
  reg  [`AIP_IS_W-1:0]  ist_reg;
  reg  [`AIP_IS_W-1:0]  imask_reg;
  reg  [`AIP_IS_W-1:0]  ist_set;
  reg                   direct;
  reg                   exec;
  reg  [7:0]            op;
  reg  [7:0]            typ;
  reg  [7:0]            bank;
  reg                   known;
  reg  [7:0]            status;
  wire [4:0]            irq_num;
  reg  [`AIP_IRQ_N-1:0] en_sel;
  reg                   en_on;
  reg                   en_off;
  reg                   gie_next;
  wire [`AIP_IRQ_N-1:0] irq_en_next;
  wire [`AIP_EF_W-1:0]  err_next;
  wire [`AIP_IS_W-1:0]  ist_next;
  wire                  status_wr;
  reg  [7:0]            reply_sum;
  genvar                g;

  assign ERR_FLAGS     = err_reg;
  assign IRQ_EN        = irq_en_reg;
  assign IRQ_GLOBAL_EN = gie_reg;
  assign irq_num       = typ[4:0];
  assign IRQ           = |(ist_reg & imask_reg);
  assign status_wr     = REG_WR && (REG_ADDR == `AIP_REG_STATUS);

  // =====================================================
  // frame reception
  aip_frame_rx u_rx (
    .clk           (CLK_SYS),
    .rst_n         (RST_N),
    .byte_valid    (RX_VALID),
    .byte_data     (RX_DATA),
    .frame_valid   (fr_valid),
    .frame_csum_ok (fr_ok),
    .frame_addr    (fr_addr),
    .frame_op      (fr_op),
    .frame_type    (fr_type),
    .frame_bank    (fr_bank),
    .frame_value   (fr_value)
  );

  // =====================================================
  // command select: direct frames win over program fetch in the same cycle
  always @* begin
    direct = fr_valid && (fr_addr == addr_reg);
    exec   = (direct && fr_ok) || (!direct && PROG_VALID);
    op     = direct ? fr_op   : PROG_OP;
    typ    = direct ? fr_type : PROG_TYPE;
    bank   = direct ? fr_bank : PROG_BANK;
    known  = (op == `AIP_OP_ACCU_AXIS) || (op == `AIP_OP_ACCU_GLOBAL) ||
             (op == `AIP_OP_CLEAR_ERR) || (op == `AIP_OP_IRQ_ENABLE) ||
             (op == `AIP_OP_IRQ_DISABLE) || (op == `AIP_OP_IRQ_RETURN);
    if (!fr_ok)
      status = `AIP_ST_BAD_CSUM;
    else if (!known)
      status = `AIP_ST_BAD_CMD;
    else
      status = `AIP_ST_OK;
    reply_sum = `AIP_RST_HOST + addr_reg + status + fr_op;
  end

  // =====================================================
  // error flag clear decode; bank and value take no part
  always @* begin
    err_clr = {`AIP_EF_W{1'b0}};
    if (exec && op == `AIP_OP_CLEAR_ERR) begin
      case (typ)
        `AIP_CLE_ALL:       err_clr = {`AIP_EF_W{1'b1}};
        `AIP_CLE_TIMEOUT:   err_clr[`AIP_EF_TIMEOUT]   = 1'b1;
        `AIP_CLE_ALARM:     err_clr[`AIP_EF_ALARM]     = 1'b1;
        `AIP_CLE_DEVIATION: err_clr[`AIP_EF_DEVIATION] = 1'b1;
        `AIP_CLE_POSITION:  err_clr[`AIP_EF_POSITION]  = 1'b1;
        `AIP_CLE_SHUTDOWN:  err_clr[`AIP_EF_SHUTDOWN]  = 1'b1;
        default:            err_clr = {`AIP_EF_W{1'b0}};
      endcase
    end
  end

  // per-flag next value; a new error in the clearing cycle survives
  generate
    for (g = 0; g < `AIP_EF_W; g = g + 1) begin : g_err
      assign err_next[g] = (err_reg[g] & ~err_clr[g]) | ERR_SET[g];
    end
  endgenerate

  // =====================================================
  // interrupt enable decode: 255 is the global switch, 32..254 match no source
  always @* begin
    en_sel   = {{(`AIP_IRQ_N-1){1'b0}}, 1'b1} << irq_num;
    en_on    = exec && (op == `AIP_OP_IRQ_ENABLE) && (typ < `AIP_IRQ_N);
    en_off   = exec && (op == `AIP_OP_IRQ_DISABLE) && (typ < `AIP_IRQ_N);
    gie_next = gie_reg;
    if (exec && (typ == `AIP_IRQ_GLOBAL)) begin
      if (op == `AIP_OP_IRQ_ENABLE)
        gie_next = 1'b1;
      else if (op == `AIP_OP_IRQ_DISABLE)
        gie_next = 1'b0;
    end
  end

  // one flop input per source; the global form leaves every source as it was
  generate
    for (g = 0; g < `AIP_IRQ_N; g = g + 1) begin : g_irq_en
      assign irq_en_next[g] = (en_sel[g] && en_on)  ? 1'b1 :
                              (en_sel[g] && en_off) ? 1'b0 :
                              irq_en_reg[g];
    end
  endgenerate

  // =====================================================
  // state: error flags, interrupt enables, parameter writes
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      err_reg       <= {`AIP_EF_W{1'b0}};
      irq_en_reg    <= {`AIP_IRQ_N{1'b0}};
      gie_reg       <= 1'b0;
      PAR_WE        <= 1'b0;
      PAR_GLOBAL    <= 1'b0;
      PAR_INDEX     <= 8'h00;
      PAR_BANK      <= 8'h00;
      PAR_DATA      <= 32'h0;
    end else begin
      err_reg     <= err_next;
      irq_en_reg  <= irq_en_next;
      gie_reg     <= gie_next;
      PAR_WE      <= 1'b0;
      if (exec) begin
        case (op)
          `AIP_OP_ACCU_AXIS, `AIP_OP_ACCU_GLOBAL: begin
            PAR_WE     <= 1'b1;
            PAR_GLOBAL <= (op == `AIP_OP_ACCU_GLOBAL);
            PAR_INDEX  <= typ;
            PAR_BANK   <= bank;
            PAR_DATA   <= ACCU_IN;
          end
          default: begin
            PAR_WE <= 1'b0;
          end
        endcase
      end
    end
  end

  // =====================================================
  // context restore on return from an interrupt routine
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RESTORE_STB   <= 1'b0;
      RESTORE_ACCU  <= 32'h0;
      RESTORE_X     <= 32'h0;
      RESTORE_FLAGS <= 8'h00;
      RESTORE_PC    <= 16'h0000;
    end else begin
      // strobe lasts one cycle, the restored words hold until the next return
      RESTORE_STB <= exec && (op == `AIP_OP_IRQ_RETURN);
      if (exec && (op == `AIP_OP_IRQ_RETURN)) begin
        RESTORE_ACCU  <= CTX_ACCU;
        RESTORE_X     <= CTX_X;
        RESTORE_FLAGS <= CTX_FLAGS;
        RESTORE_PC    <= CTX_PC;
      end
    end
  end

  // =====================================================
  // direct mode reply; value field carries nothing meaningful
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REPLY_VALID  <= 1'b0;
      REPLY_HOST   <= 8'h00;
      REPLY_ADDR   <= 8'h00;
      REPLY_STATUS <= 8'h00;
      REPLY_CMD    <= 8'h00;
      REPLY_VALUE  <= 32'h0;
      REPLY_CSUM   <= 8'h00;
    end else begin
      REPLY_VALID <= direct;
      if (direct) begin
        REPLY_HOST   <= `AIP_RST_HOST;
        REPLY_ADDR   <= addr_reg;
        REPLY_STATUS <= status;
        REPLY_CMD    <= fr_op;
        REPLY_VALUE  <= 32'h0;
        REPLY_CSUM   <= reply_sum;
      end
    end
  end

  // =====================================================
  // register port and interrupt status
  always @* begin
    ist_set = {`AIP_IS_W{1'b0}};
    ist_set[`AIP_IS_CMD_DONE] = exec && known;
    ist_set[`AIP_IS_CMD_ERR]  = direct && (status != `AIP_ST_OK);
  end

  // write-one-to-clear per bit; a set in the same cycle wins over the clear
  generate
    for (g = 0; g < `AIP_IS_W; g = g + 1) begin : g_ist
      assign ist_next[g] = (ist_reg[g] & ~(status_wr & REG_WDATA[g])) | ist_set[g];
    end
  endgenerate

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ist_reg   <= {`AIP_IS_W{1'b0}};
      imask_reg <= {`AIP_IS_W{1'b0}};
      addr_reg  <= `AIP_RST_ADDR;
      REG_RDATA <= 32'h0;
    end else begin
      ist_reg <= ist_next;
      if (REG_WR && REG_ADDR == `AIP_REG_MASK)
        imask_reg <= REG_WDATA[`AIP_IS_W-1:0];
      if (REG_WR && REG_ADDR == `AIP_REG_ADDR)
        addr_reg <= REG_WDATA[7:0];
      REG_RDATA <= 32'h0;
      if (REG_RD) begin
        case (REG_ADDR)
          `AIP_REG_STATUS:    REG_RDATA <= {{(32-`AIP_IS_W){1'b0}}, ist_reg};
          `AIP_REG_MASK:      REG_RDATA <= {{(32-`AIP_IS_W){1'b0}}, imask_reg};
          `AIP_REG_ERRFLAGS:  REG_RDATA <= {{(32-`AIP_EF_W){1'b0}}, err_reg};
          `AIP_REG_IRQEN:     REG_RDATA <= irq_en_reg;
          `AIP_REG_GLOBAL_EN: REG_RDATA <= {31'h0, gie_reg};
          `AIP_REG_ADDR:      REG_RDATA <= {24'h0, addr_reg};
          `AIP_REG_ACCU:      REG_RDATA <= ACCU_IN;
          default:            REG_RDATA <= 32'h0;
        endcase
      end
    end
  end
endmodule // aip_cmd_exec

// [testbench/aip_cmd_exec_properties.sv]
// concurrent checks on the command executor ports
`timescale 1ns/100ps
`include "aip_consts.vh"
module aip_cmd_exec_properties (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic [31:0] ACCU_IN,
  input wire logic [31:0] CTX_ACCU,
  input wire logic        PAR_WE,
  input wire logic [31:0] PAR_DATA,
  input wire logic [31:0] IRQ_EN,
  input wire logic        IRQ_GLOBAL_EN,
  input wire logic        RESTORE_STB,
  input wire logic [31:0] RESTORE_ACCU,
  input wire logic        REPLY_VALID,
  input wire logic [7:0]  REPLY_HOST,
  input wire logic [7:0]  REPLY_ADDR,
  input wire logic [7:0]  REPLY_STATUS,
  input wire logic [7:0]  REPLY_CMD,
  input wire logic [31:0] REPLY_VALUE,
  input wire logic [7:0]  REPLY_CSUM
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ==========================================
  // port relations
  chk_par_accu: assert property (PAR_WE |-> PAR_DATA == $past(ACCU_IN))
    else $error("parameter data differs from accumulator");
  chk_par_ok: assert property (PAR_WE && REPLY_VALID |-> REPLY_STATUS == `AIP_ST_OK)
    else $error("parameter copy without ok status");
  chk_reply_fixed: assert property (REPLY_VALID |-> REPLY_HOST == `AIP_RST_HOST && REPLY_VALUE == 32'h0)
    else $error("reply host or value wrong");
  chk_reply_csum: assert property (REPLY_VALID |->
      REPLY_CSUM == 8'(REPLY_HOST + REPLY_ADDR + REPLY_STATUS + REPLY_CMD))
    else $error("reply checksum wrong");
  // nine bytes per frame, so replies can never come closer than nine cycles
  chk_reply_gap: assert property (REPLY_VALID |=> !REPLY_VALID [*8])
    else $error("replies too close");
  chk_err_refuse: assert property (REPLY_VALID && REPLY_STATUS != `AIP_ST_OK |->
      !PAR_WE && !RESTORE_STB && $stable(IRQ_EN) && $stable(IRQ_GLOBAL_EN))
    else $error("refused command had an effect");
  chk_glob_keeps: assert property ($changed(IRQ_GLOBAL_EN) |-> $stable(IRQ_EN))
    else $error("global switch touched single enables");
  chk_en_onebit: assert property ($changed(IRQ_EN) |-> $onehot(IRQ_EN ^ $past(IRQ_EN)))
    else $error("more than one enable changed");
  chk_restore_ctx: assert property (RESTORE_STB |-> RESTORE_ACCU == $past(CTX_ACCU))
    else $error("restored accumulator wrong");
endmodule // aip_cmd_exec_properties

bind aip_cmd_exec aip_cmd_exec_properties i_aip_cmd_exec_properties (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ACCU_IN(ACCU_IN), .CTX_ACCU(CTX_ACCU), .PAR_WE(PAR_WE),
  .PAR_DATA(PAR_DATA), .IRQ_EN(IRQ_EN), .IRQ_GLOBAL_EN(IRQ_GLOBAL_EN), .RESTORE_STB(RESTORE_STB),
  .RESTORE_ACCU(RESTORE_ACCU), .REPLY_VALID(REPLY_VALID), .REPLY_HOST(REPLY_HOST),
  .REPLY_ADDR(REPLY_ADDR), .REPLY_STATUS(REPLY_STATUS), .REPLY_CMD(REPLY_CMD),
  .REPLY_VALUE(REPLY_VALUE), .REPLY_CSUM(REPLY_CSUM));

// [testbench/aip_host_model.sv]
// host side model sending nine-byte command frames
`timescale 1ns/100ps
module aip_host_model (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // idle line shows the inverse of the last byte so stale data never looks valid
  task send(input [7:0] a, input [7:0] op, input [7:0] ty, input [7:0] bk,
            input [31:0] v, input bad, input [1:0] gap);
    logic [7:0] b [0:8];
    integer i, j;
    begin
      {b[0], b[1], b[2], b[3]} = {a, op, ty, bk};
      {b[4], b[5], b[6], b[7]} = v;
      b[8] = {7'h00, bad};
      for (i = 0; i < 8; i++) b[8] = b[8] + b[i];
      for (i = 0; i < 9; i++) begin
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b[i];
        for (j = 0; j < gap; j++) begin
          @(posedge clk);
          rx_valid <= 1'b0;
          rx_data <= ~b[i];
        end
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~b[8];
    end
  endtask
endmodule // aip_host_model

// [testbench/aip_cmd_exec_tb_top.sv]
// self-checking bench for the command executor
`timescale 1ns/100ps
`include "aip_consts.vh"
module aip_cmd_exec_tb_top;
  logic        clk, rst_n, pv, wr_s, rd_s, par_we, par_gl, rs_stb, rep_v, irq, glob, rx_v;
  logic [7:0]  p_op, p_ty, rx_d, p_idx, p_bk, r_st, r_cmd, c_fl, x_st, x_cmd, x_ty, x_bk, addr;
  logic [7:0]  p_bank, r_host, r_adr, r_cs;
  logic [31:0] accu, c_acc, c_x, wdata, rdata, en_o, p_dat, rs_acc, rs_x, en, r_val;
  logic [15:0] c_pc, rs_pc;
  logic [7:0]  rs_fl;
  logic [4:0]  eset, ef_o;
  logic [3:0]  radr;
  integer      num_errors, checks, cyc, n_rep, n_par, n_rst, ef, gl, i;

  aip_host_model i_aip_host_model (.clk(clk), .rx_valid(rx_v), .rx_data(rx_d));
  aip_cmd_exec i_aip_cmd_exec (
    .CLK_SYS(clk), .RST_N(rst_n), .RX_VALID(rx_v), .RX_DATA(rx_d), .PROG_VALID(pv), .PROG_OP(p_op),
    .PROG_TYPE(p_ty), .PROG_BANK(p_bank), .PROG_VALUE(32'h0), .ACCU_IN(accu), .ERR_SET(eset),
    .CTX_ACCU(c_acc), .CTX_X(c_x), .CTX_FLAGS(c_fl), .CTX_PC(c_pc), .PAR_WE(par_we), .PAR_GLOBAL(par_gl),
    .PAR_INDEX(p_idx), .PAR_BANK(p_bk), .PAR_DATA(p_dat), .ERR_FLAGS(ef_o), .IRQ_EN(en_o),
    .IRQ_GLOBAL_EN(glob), .RESTORE_STB(rs_stb), .RESTORE_ACCU(rs_acc), .RESTORE_X(rs_x),
    .RESTORE_FLAGS(rs_fl), .RESTORE_PC(rs_pc), .REPLY_VALID(rep_v), .REPLY_HOST(r_host), .REPLY_ADDR(r_adr),
    .REPLY_STATUS(r_st), .REPLY_CMD(r_cmd), .REPLY_VALUE(r_val), .REPLY_CSUM(r_cs), .REG_ADDR(radr),
    .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .IRQ(irq));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (num_errors == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ==========================================
  // result monitor
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
    if (rep_v === 1'b1) begin
      n_rep = n_rep + 1;
      check({r_st, r_cmd}, {x_st, x_cmd});
      check({r_host, r_adr, r_cs}, {`AIP_RST_HOST, addr, 8'(`AIP_RST_HOST + addr + x_st + x_cmd)});
      check(r_val, 32'h0);
    end
    if (par_we === 1'b1) begin
      n_par = n_par + 1;
      check({par_gl, p_idx, p_bk}, {x_cmd == `AIP_OP_ACCU_GLOBAL, x_ty, x_bk});
      check(p_dat, accu);
    end
    if (rs_stb === 1'b1) begin
      n_rst = n_rst + 1;
      check(rs_x, c_x);
      check(rs_acc, c_acc);
      check({rs_fl, rs_pc}, {c_fl, c_pc});
    end
  end
  // ==========================================
  // stimulus tasks
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr_s <= 1'b1;
      radr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, input [31:0] x);
    begin
      @(posedge clk);
      rd_s <= 1'b1;
      radr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      check(rdata, x);
    end
  endtask
  task cmd(input [7:0] a, input [7:0] op, input [7:0] ty, input bad);
    integer r, p, s;
    begin
      {r, p, s} = {n_rep, n_par, n_rst};
      {x_cmd, x_ty, x_bk} = {op, ty, 8'($urandom)};
      x_st = bad ? `AIP_ST_BAD_CSUM : `AIP_ST_OK;
      if (!bad && a == addr) case (op)
        `AIP_OP_ACCU_AXIS, `AIP_OP_ACCU_GLOBAL, `AIP_OP_IRQ_RETURN: ;
        `AIP_OP_CLEAR_ERR: ef = ty == 0 ? 0 : ty <= 5 ? ef & ~(1 << (ty - 1)) : ef;
        `AIP_OP_IRQ_ENABLE: if (ty == 255) gl = 1; else if (ty < 32) en[ty[4:0]] = 1'b1;
        `AIP_OP_IRQ_DISABLE: if (ty == 255) gl = 0; else if (ty < 32) en[ty[4:0]] = 1'b0;
        default: x_st = `AIP_ST_BAD_CMD;
      endcase
      i_aip_host_model.send(a, op, ty, x_bk, $urandom, bad, 2'($urandom_range(0, 1)));
      repeat (3) @(posedge clk);
      #1;
      check(n_rep, r + (a == addr));
      check(n_par, p + (x_st == `AIP_ST_OK && a == addr && (op == 8'h22 || op == 8'h23)));
      check(n_rst, s + (x_st == `AIP_ST_OK && a == addr && op == `AIP_OP_IRQ_RETURN));
      check(ef_o, ef[4:0]);
      check(en_o, en);
      check(glob, gl[0]);
    end
  endtask
  task set_flags;
    begin
      @(posedge clk);
      eset <= 5'h1f;
      @(posedge clk);
      eset <= 5'h00;
      ef = 31;
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, pv, wr_s, rd_s, p_op, p_ty, p_bank, eset, radr, wdata, c_fl, c_pc} = 0;
    {accu, c_acc, c_x, en, x_cmd, x_ty, x_bk, x_st} = 0;
    {num_errors, checks, cyc, n_rep, n_par, n_rst, ef, gl} = 0;
    addr = 8'h01;
    i = $urandom(32'h3ef84b06);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`AIP_REG_ADDR, 32'h1);
    rd(`AIP_REG_ERRFLAGS, 32'h0);
    rd(4'h7, 32'h0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      accu <= $urandom;
      cmd(addr, `AIP_OP_ACCU_AXIS + i % 2, $urandom, 0);
    end
    rd(`AIP_REG_ACCU, accu);
    // type 6 first shows an unknown code clears nothing
    for (i = 6; i >= 0; i--) begin
      if (i == 6 || i == 0) set_flags;
      cmd(addr, `AIP_OP_CLEAR_ERR, i, 0);
    end
    for (i = 0; i < 12; i++)
      cmd(addr, i % 3 == 2 ? `AIP_OP_IRQ_DISABLE : `AIP_OP_IRQ_ENABLE, i % 4 == 0 ? 255 : $urandom_range(0, 40), 0);
    rd(`AIP_REG_IRQEN, en);
    @(posedge clk);
    {c_acc, c_x, c_fl, c_pc} <= {$urandom, $urandom, 8'($urandom), 16'($urandom)};
    cmd(addr, `AIP_OP_IRQ_RETURN, 8'hff, 0);
    cmd(addr, `AIP_OP_IRQ_ENABLE, 8'h05, 1);
    cmd(addr, 8'h30, 8'h05, 0);
    cmd(addr + 8'h01, `AIP_OP_IRQ_ENABLE, 8'h07, 0);
    wr(`AIP_REG_STATUS, 32'h3);
    wr(`AIP_REG_MASK, 32'h0);
    cmd(addr, `AIP_OP_IRQ_ENABLE, 8'h09, 0);
    rd(`AIP_REG_STATUS, 32'h1);
    check(irq, 1'b0);
    wr(`AIP_REG_MASK, 32'h1);
    check(irq, 1'b1);
    wr(`AIP_REG_STATUS, 32'h1);
    check(irq, 1'b0);
    wr(`AIP_REG_ADDR, 32'h2a);
    rd(`AIP_REG_ADDR, 32'h2a);
    addr = 8'h2a;
    cmd(8'h01, `AIP_OP_IRQ_DISABLE, 8'h09, 0);
    cmd(addr, `AIP_OP_IRQ_DISABLE, 8'h09, 0);
    i = n_par;
    {x_cmd, x_ty, x_bk} = {`AIP_OP_ACCU_GLOBAL, 8'($urandom), 8'($urandom)};
    @(posedge clk);
    {pv, p_op, p_ty, p_bank} <= {1'b1, x_cmd, x_ty, x_bk};
    @(posedge clk);
    pv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(n_par, i + 1);
    i = n_rep;
    x_cmd = `AIP_OP_IRQ_ENABLE;
    x_ty = 8'($urandom_range(0, 31));
    en[x_ty[4:0]] = 1'b1;
    @(posedge clk);
    pv <= 1'b1;
    p_op <= x_cmd;
    p_ty <= x_ty;
    @(posedge clk);
    pv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(en_o, en);
    check(n_rep, i);
    test_done;
  end
endmodule // aip_cmd_exec_tb_top
